/* File: verilog/ptl_defs.svh */
`ifndef PTL_DEFS_SVH
`define PTL_DEFS_SVH
`define PTL_NUM_INPUTS  68
`define PTL_NUM_LINES   136
`define PTL_NUM_TERMS   163
`define PTL_LOGIC_TERMS 160
`define PTL_NUM_MCS     32
`define PTL_CLUSTER     5
`define PTL_CHAIN_STEP  7
`define PTL_SHARE_REACH 3
`define PTL_SHARE_WIDTH 7
`define PTL_EXT_FB      16
`define PTL_SEG_OUTS    48
`define PTL_SEG_POOL    384
`define PTL_GLOB_TO_SEG 192
`define PTL_NUM_GCLK    4
`define PTL_SH_CLK_TERM 160
`define PTL_SH_RST_TERM 161
`define PTL_SH_OE_TERM  162
`define PTL_CL_OE       0
`define PTL_CL_CE       1
`define PTL_CL_CLK      2
`define PTL_CL_SET      3
`define PTL_CL_RST      4
`define PTL_AND_WORDS   5
`define PTL_ADDR_W      12
`define PTL_MC_BASE     12'h800
`define PTL_BLK_CFG     12'hC00
`define PTL_OE_MASK     12'hC01
`define PTL_STATUS      12'hC02
`define PTL_MC_CFG_RST  32'h0000_0000
`define PTL_BLK_CFG_RST 8'h00
`define PTL_OE_MASK_RST 32'h0000_0000
`endif

/* File: verilog/ptl_pkg.sv */
package ptl_pkg;
`include "ptl_defs.svh"
   typedef enum logic [2:0] {
      PTL_CLK_B0 = 3'h0, PTL_CLK_B1 = 3'h1, PTL_CLK_B2 = 3'h2, PTL_CLK_B3 = 3'h3,
      PTL_CLK_PT = 3'h4, PTL_CLK_SHARED = 3'h5
   } ptl_clk_src_t;
   typedef enum logic [1:0] {
      PTL_CTL_OFF = 2'h0, PTL_CTL_GLOBAL = 2'h1, PTL_CTL_TERM = 2'h2, PTL_CTL_SHARED = 2'h3
   } ptl_ctl_src_t;
   typedef enum logic [1:0] {
      PTL_BCLK_TRUE = 2'h0, PTL_BCLK_INV = 2'h1, PTL_BCLK_ADJ = 2'h2, PTL_BCLK_ADJ2 = 2'h3
   } ptl_bclk_mode_t;
   typedef struct packed {
      ptl_ctl_src_t rst_sel;
      ptl_ctl_src_t set_sel;
      ptl_ctl_src_t ce_sel;
      ptl_clk_src_t clk_sel;
      logic         io_in;
      logic         latch;
      logic         registered;
      logic         xor_inv;
      logic         use_bypass;
      logic [6:0]   share_mask;
      logic         chain_en;
      logic [4:0]   exp_sel;
      logic [4:0]   byp_sel;
   } ptl_mc_cfg_t;
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [31:0] wdata;
   } ptl_bus_req_t;
   typedef struct packed {
      logic d;
      logic clk;
      logic ce;
      logic set;
      logic rst;
      logic latch;
   } ptl_store_in_t;
endpackage

/* File: verilog/ptl_and_array.sv */
`timescale 1ns/1ps
`include "ptl_defs.svh"
module ptl_and_array (
   // Clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 reset,
   // Fuse access
   input  wire ptl_pkg::ptl_bus_req_t bus,
   output logic [31:0]               fuse_word,
   // Array
   input  wire logic [67:0]          pool_in,
   output logic [162:0]              terms
);
   import ptl_pkg::*;
   logic [31:0] fuse_mem [0:`PTL_NUM_TERMS-1][0:`PTL_AND_WORDS-1];
   logic [135:0] lines;
   logic         hit;
   // Same address map serves write and read
   assign hit = !bus.addr[11] && (bus.addr[2:0] < 3'h5) && (bus.addr[10:3] < 8'hA3);
   assign lines = {~pool_in, pool_in};
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         for (int t = 0; t < `PTL_NUM_TERMS; t++) begin
            for (int w = 0; w < `PTL_AND_WORDS; w++) begin
               fuse_mem[t][w] <= 32'h0000_0000;
            end
         end
      end else if (bus.wr && hit) begin
         fuse_mem[bus.addr[10:3]][bus.addr[2:0]] <= bus.wdata;
      end
   end
   assign fuse_word = hit ? fuse_mem[bus.addr[10:3]][bus.addr[2:0]] : 32'h0000_0000;
   for (genvar t = 0; t < `PTL_NUM_TERMS; t++) begin : g_term
      logic [159:0] fuse;
      assign fuse = {fuse_mem[t][4], fuse_mem[t][3], fuse_mem[t][2],
                     fuse_mem[t][1], fuse_mem[t][0]};
      // Unconnected lines drop out, so an empty term is true
      assign terms[t] = &(lines | ~fuse[135:0]);
   end
endmodule

/* File: verilog/ptl_macrocell.sv */
`timescale 1ns/1ps
module ptl_macrocell (
   // Clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  reset,
   // Storage control
   input  wire ptl_pkg::ptl_store_in_t ctl,
   // Stored value
   output logic                       q
);
   import ptl_pkg::*;
   typedef struct packed {
      logic clk_prev;
      logic q;
   } ptl_store_t;
   ptl_store_t st_reg;
   ptl_store_t st_next;
   always_comb begin
      st_next = st_reg;
      st_next.clk_prev = ctl.clk;
      if (ctl.rst) begin
         st_next.q = 1'b0;
      end else if (ctl.set) begin
         st_next.q = 1'b1;
      end else if (ctl.ce) begin
         // Latch follows the level, flop only the rising edge
         if (ctl.latch) begin
            if (ctl.clk) st_next.q = ctl.d;
         end else if (ctl.clk && !st_reg.clk_prev) begin
            st_next.q = ctl.d;
         end
      end
   end
   always_ff @(posedge sys_clk or posedge reset) begin
      // Starts high so a clock idling high gives no false edge
      if (reset) st_reg <= '{clk_prev: 1'b1, q: 1'b0};
      else st_reg <= st_next;
   end
   assign q = st_reg.q;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   property p_rst_wins;
      ctl.rst && ctl.set |=> !q;
   endproperty
   a_rst_wins: assert property (p_rst_wins) else $error("reset lost to preset");
   property p_preset;
      ctl.set && !ctl.rst |=> q;
   endproperty
   a_preset: assert property (p_preset) else $error("preset not taken");
   property p_latch_open;
      ctl.latch && ctl.clk && ctl.ce && !ctl.set && !ctl.rst |=> q == $past(ctl.d);
   endproperty
   a_latch_open: assert property (p_latch_open) else $error("latch not transparent");
   property p_flop_hold;
      !ctl.latch && !ctl.rst && !ctl.set && !(ctl.clk && !st_reg.clk_prev) |=> $stable(q);
   endproperty
   a_flop_hold: assert property (p_flop_hold) else $error("flop moved without edge");
endmodule

/* File: verilog/ptl_logic_block.sv */
// How it works
// - 68 inputs, true and complement, into 163 terms
// - 160 logic terms; three shared control terms
// - Five-term clusters from term zero, one each
// - Cluster terms give enable, clock, preset, reset
// - Two OR gates per macrocell, 64 total
// - Bypass OR feeds its macrocell directly
// - Expandable OR chains from N-7 to N+7
// - Sharing output ORs results N-3 to N+3
// - Sharing neighbours wrap around the 32 macrocells
// - Macrocell picks sharing or bypass input
// - XOR stage, then combinational or stored
// - Two concurrent outputs per macrocell
// - Storage may load straight from I/O
// - Clock and clock enable selectable, no gating
// - Preset and reset from global or term
// - Storage is flip-flop or transparent latch
// - 48 segment outputs: 32 internal, 16 external
// - Shared enable term goes to I/O cells
// - Block clock: true, inverted, or adjacent inverted
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
`include "ptl_defs.svh"
module ptl_logic_block (
   // Clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 reset,
   // Register port
   input  wire ptl_pkg::ptl_bus_req_t bus,
   output logic [31:0]               rd_data,
   // Routing pool inputs
   input  wire logic [67:0]          pool_in,
   // Global controls
   input  wire logic [3:0]           gclk,
   input  wire logic                 glob_ce,
   input  wire logic                 glob_set,
   input  wire logic                 glob_rst,
   // I/O cell side
   input  wire logic [31:0]          io_in,
   output logic [31:0]               io_out,
   output logic [31:0]               io_oe,
   output logic                      shared_oe,
   // Routing pool outputs
   output logic [47:0]               seg_out,
   output logic [31:0]               glob_out
);
   import ptl_pkg::*;

   typedef struct packed {
      ptl_mc_cfg_t [31:0] mc_cfg;
      logic [7:0]         bclk_cfg;
      logic [31:0]        oe_mask;
      logic [31:0]        rd_data;
      logic [31:0]        io_out;
      logic [31:0]        io_oe;
      logic               shared_oe;
      logic [47:0]        seg_out;
      logic [31:0]        glob_out;
   } ptl_top_t;

   ptl_top_t st_reg;
   ptl_top_t st_next;

   logic [162:0] terms;
   logic [31:0]  fuse_word;
   logic [3:0]   bclk;
   logic [31:0]  byp;
   logic [31:0]  exp_or;
   logic [31:0]  shr;
   logic [31:0]  xr;
   logic [31:0]  alt;
   logic [31:0]  out0;
   logic [31:0]  pt_oe;
   logic [31:0]  q_v;

   function automatic int mc_wrap(input int i);
      return (i + `PTL_NUM_MCS) % `PTL_NUM_MCS;
   endfunction

   // Bit k of the result is neighbour n-3+k
   function automatic logic [6:0] share_pick(input logic [31:0] v, input int n);
      logic [6:0] r;
      r = 7'h00;
      for (int k = 0; k < `PTL_SHARE_WIDTH; k++) begin
         r[k] = v[mc_wrap(n + k - `PTL_SHARE_REACH)];
      end
      return r;
   endfunction

   function automatic logic ctl_pick(input ptl_ctl_src_t s, input logic g,
                                     input logic t, input logic sh);
      case (s)
         PTL_CTL_OFF:    ctl_pick = 1'b0;
         PTL_CTL_GLOBAL: ctl_pick = g;
         PTL_CTL_TERM:   ctl_pick = t;
         PTL_CTL_SHARED: ctl_pick = sh;
         default:        ctl_pick = 1'b0;
      endcase
   endfunction

   function automatic logic clk_pick(input ptl_clk_src_t s, input logic [3:0] b,
                                     input logic t, input logic sh);
      case (s)
         PTL_CLK_B0:     clk_pick = b[0];
         PTL_CLK_B1:     clk_pick = b[1];
         PTL_CLK_B2:     clk_pick = b[2];
         PTL_CLK_B3:     clk_pick = b[3];
         PTL_CLK_PT:     clk_pick = t;
         PTL_CLK_SHARED: clk_pick = sh;
         default:        clk_pick = b[0];
      endcase
   endfunction

   function automatic logic is_mc(input logic [11:0] a);
      return a[11:5] == 7'(`PTL_MC_BASE >> 5);
   endfunction

   ptl_and_array u_and (
      .sys_clk   (sys_clk),
      .reset     (reset),
      .bus       (bus),
      .fuse_word (fuse_word),
      .pool_in   (pool_in),
      .terms     (terms)
   );

   // Block clocks from the global clocks, sampled as levels
   for (genvar k = 0; k < `PTL_NUM_GCLK; k++) begin : g_bclk
      ptl_bclk_mode_t m;
      assign m = ptl_bclk_mode_t'(st_reg.bclk_cfg[2*k +: 2]);
      always_comb begin
         case (m)
            PTL_BCLK_TRUE: bclk[k] = gclk[k];
            PTL_BCLK_INV:  bclk[k] = ~gclk[k];
            default:       bclk[k] = ~gclk[k ^ 1];
         endcase
      end
   end

   for (genvar n = 0; n < `PTL_NUM_MCS; n++) begin : g_mc
      ptl_mc_cfg_t   c;
      logic [4:0]    clus;
      logic [6:0]    nb;
      logic          sel_in;
      ptl_store_in_t sctl;
      assign c = st_reg.mc_cfg[n];
      assign clus = terms[`PTL_CLUSTER*n +: `PTL_CLUSTER];
      assign pt_oe[n] = clus[`PTL_CL_OE];
      assign byp[n] = |(clus & c.byp_sel);
      if (n >= `PTL_CHAIN_STEP) begin : g_chain
         assign exp_or[n] = |(clus & c.exp_sel) | (c.chain_en & exp_or[n-`PTL_CHAIN_STEP]);
      end else begin : g_head
         assign exp_or[n] = |(clus & c.exp_sel);
      end
      assign nb = share_pick(exp_or, n);
      assign shr[n] = |(c.share_mask & nb);
      assign sel_in = c.use_bypass ? byp[n] : shr[n];
      assign xr[n] = sel_in ^ c.xor_inv;
      // Second output carries whichever path the main one leaves
      assign alt[n] = (c.use_bypass ? shr[n] : byp[n]) ^ c.xor_inv;
      assign sctl.d = c.io_in ? io_in[n] : xr[n];
      assign sctl.clk = clk_pick(c.clk_sel, bclk, clus[`PTL_CL_CLK],
                                 terms[`PTL_SH_CLK_TERM]);
      // Enable left off means always enabled, never a gated clock
      assign sctl.ce = (c.ce_sel == PTL_CTL_OFF) ? 1'b1 :
                       ctl_pick(c.ce_sel, glob_ce, clus[`PTL_CL_CE], glob_ce);
      assign sctl.set = ctl_pick(c.set_sel, glob_set, clus[`PTL_CL_SET], 1'b0);
      assign sctl.rst = ctl_pick(c.rst_sel, glob_rst, clus[`PTL_CL_RST],
                                 terms[`PTL_SH_RST_TERM]);
      assign sctl.latch = c.latch;
      ptl_macrocell u_store (
         .sys_clk (sys_clk),
         .reset   (reset),
         .ctl     (sctl),
         .q       (q_v[n])
      );
      assign out0[n] = c.registered ? q_v[n] : xr[n];
   end

   always_comb begin
      st_next = st_reg;
      st_next.rd_data = 32'h0000_0000;
      if (bus.wr) begin
         if (is_mc(bus.addr)) begin
            st_next.mc_cfg[bus.addr[4:0]] = ptl_mc_cfg_t'(bus.wdata);
         end else if (bus.addr == `PTL_BLK_CFG) begin
            st_next.bclk_cfg = bus.wdata[7:0];
         end else if (bus.addr == `PTL_OE_MASK) begin
            st_next.oe_mask = bus.wdata;
         end
      end
      // Unmapped reads return zero; status is read only
      if (bus.rd) begin
         if (!bus.addr[11]) begin
            st_next.rd_data = fuse_word;
         end else if (is_mc(bus.addr)) begin
            st_next.rd_data = st_reg.mc_cfg[bus.addr[4:0]];
         end else if (bus.addr == `PTL_BLK_CFG) begin
            st_next.rd_data = {24'h00_0000, st_reg.bclk_cfg};
         end else if (bus.addr == `PTL_OE_MASK) begin
            st_next.rd_data = st_reg.oe_mask;
         end else if (bus.addr == `PTL_STATUS) begin
            st_next.rd_data = q_v;
         end
      end
      st_next.io_out = out0;
      st_next.io_oe = st_reg.oe_mask & pt_oe;
      st_next.shared_oe = terms[`PTL_SH_OE_TERM];
      st_next.seg_out = {io_in[`PTL_EXT_FB-1:0], out0};
      st_next.glob_out = alt;
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         st_reg <= '0;
         for (int i = 0; i < `PTL_NUM_MCS; i++) begin
            st_reg.mc_cfg[i] <= ptl_mc_cfg_t'(`PTL_MC_CFG_RST);
         end
         st_reg.bclk_cfg <= `PTL_BLK_CFG_RST;
         st_reg.oe_mask <= `PTL_OE_MASK_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rd_data = st_reg.rd_data;
   assign io_out = st_reg.io_out;
   assign io_oe = st_reg.io_oe;
   assign shared_oe = st_reg.shared_oe;
   assign seg_out = st_reg.seg_out;
   assign glob_out = st_reg.glob_out;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   property p_shared_oe;
      terms[`PTL_SH_OE_TERM] |=> shared_oe;
   endproperty
   a_shared_oe: assert property (p_shared_oe) else $error("shared enable lost");

   property p_bypass_out;
      st_reg.mc_cfg[0].use_bypass && !st_reg.mc_cfg[0].registered
         |=> io_out[0] == $past(byp[0] ^ st_reg.mc_cfg[0].xor_inv);
   endproperty
   a_bypass_out: assert property (p_bypass_out) else $error("bypass path wrong");

   property p_wrap;
      st_reg.mc_cfg[0].share_mask[0] && exp_or[29] |-> shr[0];
   endproperty
   a_wrap: assert property (p_wrap) else $error("sharing does not wrap");

   property p_share_off;
      st_reg.mc_cfg[5].share_mask == 7'h00 |-> !shr[5];
   endproperty
   a_share_off: assert property (p_share_off) else $error("sharing leaks");

   property p_chain;
      st_reg.mc_cfg[7].chain_en && exp_or[0]
         |-> exp_or[7] && (!st_reg.mc_cfg[14].chain_en || exp_or[14]);
   endproperty
   a_chain: assert property (p_chain) else $error("expansion chain broken");

   property p_oe;
      ##1 io_oe == $past(st_reg.oe_mask & pt_oe);
   endproperty
   a_oe: assert property (p_oe) else $error("term enable wrong");

   property p_ext_fb;
      ##1 seg_out[47:32] == $past(io_in[15:0]);
   endproperty
   a_ext_fb: assert property (p_ext_fb) else $error("external feedback wrong");

   property p_shared_rst;
      st_reg.mc_cfg[0].rst_sel == PTL_CTL_SHARED && terms[`PTL_SH_RST_TERM] |=> !q_v[0];
   endproperty
   a_shared_rst: assert property (p_shared_rst) else $error("shared reset ignored");

   property p_dual_out;
      ##1 glob_out == $past(alt);
   endproperty
   a_dual_out: assert property (p_dual_out) else $error("second output wrong");

   c_chain: cover property (st_reg.mc_cfg[7].chain_en && exp_or[0] ##1 io_out[7]);
   c_latch: cover property (st_reg.mc_cfg[0].latch && st_reg.mc_cfg[0].registered ##1 q_v[0]);
   c_io_reg: cover property (st_reg.mc_cfg[2].io_in && io_in[2] ##2 q_v[2]);
endmodule

/* File: sim/ptl_pool_model.sv */
`timescale 1ns/1ps
module ptl_pool_model (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset,
   // Levels asked for by the bench
   input  wire logic [67:0] pool_set,
   input  wire logic [31:0] io_set,
   input  wire logic [3:0]  clk_set,
   // Pool and pin side
   output logic      [67:0] pool_in,
   output logic      [31:0] io_in,
   output logic      [3:0]  gclk
);
   // Registered, so every level moves just after an edge, never on it
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pool_in <= 68'h0;
         io_in   <= 32'h0;
         gclk    <= 4'h0;
      end else begin
         pool_in <= pool_set;
         io_in   <= io_set;
         gclk    <= clk_set;
      end
   end
endmodule

/* File: sim/tb.sv */
`timescale 1ns/1ps
`include "ptl_defs.svh"
module tb;
   import ptl_pkg::*;
   logic         sys_clk, reset, glob_ce, glob_set, glob_rst, shared_oe, q_exp;
   ptl_bus_req_t bus;
   ptl_mc_cfg_t  c;
   logic [31:0]  rd_data, io_out, io_oe, glob_out, io_val, io_in, rv, r, lfsr_state;
   logic [67:0]  pool_val, pool_in;
   logic [95:0]  w;
   logic [3:0]   gclk_val, gclk;
   logic [47:0]  seg_out;
   int           fail_count, n_compared, m, j, k, comp, inv;

   ptl_logic_block u_dut (.sys_clk(sys_clk), .reset(reset), .bus(bus), .rd_data(rd_data),
      .pool_in(pool_in), .gclk(gclk), .glob_ce(glob_ce), .glob_set(glob_set),
      .glob_rst(glob_rst), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
      .shared_oe(shared_oe), .seg_out(seg_out), .glob_out(glob_out));
   ptl_pool_model u_pool (.sys_clk(sys_clk), .reset(reset), .pool_set(pool_val),
      .io_set(io_val), .clk_set(gclk_val), .pool_in(pool_in), .io_in(io_in), .gclk(gclk));

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   function automatic logic [31:0] rnd();
      lfsr_state = {lfsr_state[30:0],
                    lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
      return lfsr_state;
   endfunction

   // Expected line value after the optional complement and the XOR stage
   function automatic logic exp_bit(input logic [67:0] p, input int b, input int cm,
                                    input int iv);
      return p[b] ^ cm[0] ^ iv[0];
   endfunction

   task check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task results;
      if (fail_count == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk) bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge sys_clk) bus.wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge sys_clk) bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge sys_clk) bus.rd <= 1'b0;
      #1 d = rd_data;
   endtask

   task fuse(input int t, input int l);
      wr(12'(t * 8 + l / 32), 32'h1 << (l % 32));
   endtask

   task do_reset;
      @(posedge sys_clk) reset <= 1'b1;
      pool_val <= 68'h0;
      gclk_val <= 4'h0;
      repeat (16) @(posedge sys_clk);
      reset <= 1'b0;
   endtask

   task new_pool;
      w = {rnd(), rnd(), rnd()};
      @(posedge sys_clk) pool_val <= w[67:0];
      io_val <= w[95:64];
   endtask

   task settle;
      repeat (5) @(posedge sys_clk);
      #1;
   endtask

   // Both low clocks move, so true and adjacent modes each see one rising edge
   task pulse;
      @(posedge sys_clk) gclk_val[1:0] <= ~gclk_val[1:0];
      repeat (3) @(posedge sys_clk);
      gclk_val[1:0] <= ~gclk_val[1:0];
      settle();
   endtask

   initial begin
      lfsr_state = 32'hBD9D84E8;
      fail_count = 0;
      n_compared = 0;
      reset = 1'b1;
      bus = '0;
      {pool_val, io_val, gclk_val, glob_ce, glob_set, glob_rst} = '0;
      do_reset();
      settle();
      check(io_out | glob_out | io_oe, 32'h0);
      rd(`PTL_OE_MASK, rv);
      check(rv, `PTL_OE_MASK_RST);
      wr(`PTL_STATUS, 32'hFFFF_FFFF);
      rd(`PTL_STATUS, rv);
      check(rv, 32'h0);
      rd(12'hC03, rv);
      check(rv, 32'h0);
      r = rnd();
      wr(`PTL_OE_MASK, r);
      rd(`PTL_OE_MASK, rv);
      check(rv, r);
      // Bypass path: random macrocell, cluster slot, input and polarity
      for (int i = 0; i < 8; i++) begin
         r = rnd();
         // Macrocell 0 first, where the bypass assertion looks
         m = (i == 0) ? 0 : int'(r[4:0]);
         j = int'(r[7:5]) % 5;
         k = int'(r[15:8]) % 68;
         comp = int'(r[16]);
         inv = int'(r[17]);
         do_reset();
         fuse(m * 5 + j, comp ? k + 68 : k);
         c = '0;
         c.byp_sel = 5'h01 << j;
         c.use_bypass = 1'b1;
         c.xor_inv = inv[0];
         wr(12'(`PTL_MC_BASE + m), c);
         for (int p = 0; p < 2; p++) begin
            new_pool();
            settle();
            check(32'(io_out[m]), 32'(exp_bit(w[67:0], k, comp, inv)));
            check(32'(seg_out[m]), 32'(exp_bit(w[67:0], k, comp, inv)));
            check(32'(glob_out[m]), 32'(inv));
         end
      end
      // Wrapped sharing into macrocell 0, chain from 0 into 7
      do_reset();
      fuse(145, 5);
      fuse(0, 6);
      c = '0;
      c.exp_sel = 5'h01;
      wr(12'(`PTL_MC_BASE + 29), c);
      c.share_mask = 7'h01;
      wr(`PTL_MC_BASE, c);
      c = '0;
      c.chain_en = 1'b1;
      c.share_mask = 7'h08;
      wr(12'(`PTL_MC_BASE + 7), c);
      for (int p = 0; p < 3; p++) begin
         new_pool();
         settle();
         check(32'(io_out[0]), 32'(w[5]));
         check(32'(io_out[7]), 32'(w[6]));
      end
      // Stored path, clock enable, block clock polarity, preset and reset
      do_reset();
      fuse(0, 2);
      c = '0;
      c.byp_sel = 5'h01;
      c.use_bypass = 1'b1;
      c.registered = 1'b1;
      c.clk_sel = PTL_CLK_B0;
      c.ce_sel = PTL_CTL_GLOBAL;
      c.set_sel = PTL_CTL_GLOBAL;
      c.rst_sel = PTL_CTL_GLOBAL;
      wr(`PTL_MC_BASE, c);
      q_exp = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (i == 4) begin
            @(posedge sys_clk) gclk_val[0] <= 1'b1;
            wr(`PTL_BLK_CFG, 32'h1);
         end
         r = rnd();
         @(posedge sys_clk) pool_val <= {65'h0, r[0], 2'h0};
         glob_ce <= r[1];
         settle();
         check(32'(io_out[0]), 32'(q_exp));
         if (r[1])
            q_exp = r[0];
         pulse();
         check(32'(io_out[0]), 32'(q_exp));
         rd(`PTL_STATUS, rv);
         check(rv, 32'(q_exp));
      end
      @(posedge sys_clk) glob_set <= 1'b1;
      settle();
      check(32'(io_out[0]), 32'h1);
      @(posedge sys_clk) glob_rst <= 1'b1;
      settle();
      check(32'(io_out[0]), 32'h0);
      @(posedge sys_clk) glob_set <= 1'b0;
      glob_rst <= 1'b0;
      // Latch on term clock, preset and reset, then on the shared terms
      do_reset();
      fuse(0, 9);
      fuse(`PTL_CL_CLK, 10);
      fuse(`PTL_CL_SET, 11);
      fuse(`PTL_CL_RST, 12);
      fuse(`PTL_SH_CLK_TERM, 10);
      fuse(`PTL_SH_RST_TERM, 12);
      c = '0;
      c.byp_sel = 5'h01;
      c.use_bypass = 1'b1;
      c.registered = 1'b1;
      c.latch = 1'b1;
      c.clk_sel = PTL_CLK_PT;
      c.set_sel = PTL_CTL_TERM;
      c.rst_sel = PTL_CTL_TERM;
      q_exp = 1'b0;
      for (int i = 0; i < 12; i++) begin
         if (i == 6) begin
            c.clk_sel = PTL_CLK_SHARED;
            c.rst_sel = PTL_CTL_SHARED;
         end
         if (i % 6 == 0)
            wr(`PTL_MC_BASE, c);
         r = rnd();
         @(posedge sys_clk) pool_val <= {55'h0, r[3:0], 9'h0};
         settle();
         q_exp = r[3] ? 1'b0 : (r[2] ? 1'b1 : (r[1] ? r[0] : q_exp));
         check(32'(io_out[0]), 32'(q_exp));
      end
      // Per-macrocell and shared enables, external feedback, input register
      do_reset();
      m = int'(rnd() % 32);
      fuse(m * 5, 1);
      fuse(`PTL_SH_OE_TERM, 0);
      wr(`PTL_OE_MASK, 32'h1 << m);
      // Block clock 0 from the inverted adjacent clock
      wr(`PTL_BLK_CFG, 32'h2);
      c = '0;
      c.registered = 1'b1;
      c.io_in = 1'b1;
      wr(12'(`PTL_MC_BASE + m), c);
      for (int p = 0; p < 3; p++) begin
         new_pool();
         settle();
         check(io_oe, 32'(w[1]) << m);
         check(32'(shared_oe), 32'(w[0]));
         check(32'(seg_out[47:32]), 32'(w[79:64]));
         pulse();
         pulse();
         check(32'(io_out[m]), 32'(w[64 + m]));
      end
      results();
   end

   initial begin
      #40000;
      fail_count++;
      results();
   end
endmodule
